// File: src/pcr_pkg.sv
package pcr_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;

  // Register indices, used directly as port addresses
  localparam logic [7:0] OFS_VCO_CAL = 8'h0a;
  localparam logic [7:0] OFS_PD = 8'h0b;
  localparam logic [7:0] OFS_EXACT = 8'h0c;

  // Reset values
  localparam logic [23:0] RST_VCO_CAL = 24'h002205;
  localparam logic [23:0] RST_PD = 24'h0f8061;
  localparam logic [23:0] RST_EXACT = 24'h000000;

  // Calibration register fields
  localparam int VC_RES_LSB = 0;
  localparam int VC_DIS_BIT = 11;
  localparam int VC_NOXFER_BIT = 12;
  localparam int VC_CLKSEL_LSB = 13;

  // Phase detector register fields
  localparam int PD_DEL_LSB = 0;
  localparam int PD_UP_BIT = 5;
  localparam int PD_DN_BIT = 6;
  localparam int PD_CSP_LSB = 7;
  localparam int PD_FUP_BIT = 9;
  localparam int PD_FDN_BIT = 10;
  localparam int PD_LVL_BIT = 22;

  // Exact frequency register fields
  localparam int EX_CNT_LSB = 0;
  localparam int EX_CNT_W = 14;
  localparam logic [13:0] EX_MIN_CNT = 14'h0002;

  // Calibration clock divide ratios per select code
  localparam int DIV_RATIO_1 = 4;
  localparam int DIV_RATIO_2 = 16;
  localparam int DIV_RATIO_3 = 32;
  localparam int DIV_CNT_W = 5;

  // Oscillator serial link word length
  localparam int LINK_BITS = 16;
  localparam int LINK_CNT_W = 5;

  // Window timer counter width, enough for 256 steps
  localparam int WIN_CNT_W = 9;

  // Timing: core clock period and slip thresholds, in ps
  localparam int CLK_PS = 10000;
  localparam int CSP1_PS = 5400;
  localparam int CSP2_PS = 14400;
  localparam int CSP3_PS = 24100;
  localparam int CSP1_CYC = (CSP1_PS + CLK_PS - 1) / CLK_PS;
  localparam int CSP2_CYC = (CSP2_PS + CLK_PS - 1) / CLK_PS;
  localparam int CSP3_CYC = (CSP3_PS + CLK_PS - 1) / CLK_PS;
  localparam int CSP_CNT_W = 5;
  localparam logic [4:0] CSP_SAT = 5'h1f;

  // Calibration state machine states
  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_MEASURE = 4'b0010,
    CAL_XFER = 4'b0100,
    CAL_STOP = 4'b1000
  } pcr_cal_state_t;

  // Decoded phase detector controls
  typedef struct packed {
    logic [2:0] delay_sel;
    logic up_en;
    logic dn_en;
    logic [1:0] csp;
    logic force_up;
    logic force_dn;
    logic lvl_3v3;
  } pcr_pd_cfg_t;

  // Slip threshold in core cycles for a mode code
  function automatic logic [4:0] pcr_csp_limit(input logic [1:0] mode);
    logic [4:0] lim;
    lim = CSP_SAT;
    unique case (mode)
      2'h1: lim = 5'(CSP1_CYC);
      2'h2: lim = 5'(CSP2_CYC);
      2'h3: lim = 5'(CSP3_CYC);
      2'h0: lim = CSP_SAT;
    endcase
    return lim;
  endfunction

  // Last count of the calibration divider for a select code
  function automatic logic [4:0] pcr_div_last(input logic [1:0] sel);
    logic [4:0] last;
    last = 5'h00;
    unique case (sel)
      2'h0: last = 5'h00;
      2'h1: last = 5'(DIV_RATIO_1 - 1);
      2'h2: last = 5'(DIV_RATIO_2 - 1);
      2'h3: last = 5'(DIV_RATIO_3 - 1);
    endcase
    return last;
  endfunction

endpackage

// File: src/pcr_cal_divider.sv
module pcr_cal_divider
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  output logic tick
);

  logic [DIV_CNT_W-1:0] cnt;
  logic [DIV_CNT_W-1:0] next_cnt;
  logic [DIV_CNT_W-1:0] last;

  // Wrap at the selected ratio; a shrinking ratio wraps at once
  always_comb begin
    last = pcr_div_last(sel);
    tick = (cnt >= last);
    next_cnt = tick ? 5'h00 : cnt + 5'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// File: src/pcr_window_timer.sv
module pcr_window_timer
  import pcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic step,
  input wire logic [2:0] code,
  output logic busy,
  output logic done
);

  logic [WIN_CNT_W-1:0] cnt;
  logic [WIN_CNT_W-1:0] next_cnt;
  logic [WIN_CNT_W-1:0] target;
  logic [WIN_CNT_W-1:0] code_hold;
  logic [WIN_CNT_W-1:0] next_code_hold;
  logic next_busy;
  logic next_done;

  // Count 2**code divider steps, window length latched at start
  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_code_hold = code_hold;
    target = code_hold;
    if (start) begin
      next_cnt = 9'h000;
      next_busy = 1'b1;
      next_code_hold = 9'(9'h001 << code);
    end else if (busy && step) begin
      next_cnt = cnt + 9'h001;
      if (next_cnt == target) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 9'h000;
      busy <= 1'b0;
      done <= 1'b0;
      code_hold <= 9'h001;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      code_hold <= next_code_hold;
    end
  end

endmodule

// File: src/pcr_top.sv
// Summary of operation
// - Autocalibration runs while disable bit is clear
// - Suppress bit blocks oscillator link transfers
// - Clock select divides calibration clock 1/4/16/32
// - Up output passes only when enabled
// - Down output passes only when enabled
// - Slip mode boosts current past error threshold
// - Force-up holds charge pump up on
// - Force-down holds charge pump down on
// - Level bit picks 1.8 or 3.3 V
// - Channel count two or more enables exact mode
//
// The strobed register port was left to the implementer.
module pcr_top
  import pcr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [23:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [23:0] REG_RDATA,
  input wire logic OSC_REG_WRITE,
  input wire logic [15:0] OSC_WORD,
  input wire logic RDIV_TICK,
  input wire logic DET_UP_RAW,
  input wire logic DET_DN_RAW,
  output logic CAL_ENABLED,
  output logic CAL_BUSY,
  output logic WINDOW_ACTIVE,
  output logic OSC_LINK_EN,
  output logic OSC_LINK_CLK,
  output logic OSC_LINK_DATA,
  output logic [2:0] DET_RESET_DELAY,
  output logic CP_UP,
  output logic CP_DN,
  output logic CSP_BOOST,
  output logic SDO_DRIVE_3V3,
  output logic EXACT_MODE_EN,
  output logic [13:0] EXACT_CHANNELS
);

  // Stored register words
  logic [23:0] vco_cal;
  logic [23:0] pd_word;
  logic [23:0] exact;
  logic [23:0] next_vco_cal;
  logic [23:0] next_pd_word;
  logic [23:0] next_exact;
  logic [23:0] next_rdata;

  // Decoded controls
  pcr_pd_cfg_t pd_cfg;
  logic autocal_off;
  logic xfer_block;
  logic [1:0] clk_sel;
  logic [2:0] win_code;
  logic [13:0] chan_cnt;

  // Calibration engine state
  pcr_cal_state_t state;
  pcr_cal_state_t next_state;
  logic pending;
  logic next_pending;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [15:0] word_hold;
  logic [15:0] next_word_hold;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic phase;
  logic next_phase;
  logic next_link_en;
  logic next_link_clk;
  logic next_link_data;
  logic next_cal_busy;
  logic win_start;
  logic win_busy;
  logic win_done;
  logic cal_tick;
  logic trig_ok;
  logic go;

  // Phase detector path state
  logic [4:0] err_cnt;
  logic [4:0] next_err_cnt;
  logic err;
  logic next_cp_up;
  logic next_cp_dn;
  logic next_boost;

  // Field decode from the stored words
  always_comb begin
    pd_cfg.delay_sel = pd_word[PD_DEL_LSB +: 3];
    pd_cfg.up_en = pd_word[PD_UP_BIT];
    pd_cfg.dn_en = pd_word[PD_DN_BIT];
    pd_cfg.csp = pd_word[PD_CSP_LSB +: 2];
    pd_cfg.force_up = pd_word[PD_FUP_BIT];
    pd_cfg.force_dn = pd_word[PD_FDN_BIT];
    pd_cfg.lvl_3v3 = pd_word[PD_LVL_BIT];
    autocal_off = vco_cal[VC_DIS_BIT];
    xfer_block = vco_cal[VC_NOXFER_BIT];
    clk_sel = vco_cal[VC_CLKSEL_LSB +: 2];
    win_code = vco_cal[VC_RES_LSB +: 3];
    chan_cnt = exact[EX_CNT_LSB +: EX_CNT_W];
  end

  // Register writes, full 24-bit words
  always_comb begin
    next_vco_cal = vco_cal;
    next_pd_word = pd_word;
    next_exact = exact;
    if (REG_WR) begin
      unique case (REG_ADDR)
        OFS_VCO_CAL: next_vco_cal = REG_WDATA;
        OFS_PD: next_pd_word = REG_WDATA;
        OFS_EXACT: next_exact = REG_WDATA;
        default: next_exact = exact;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      vco_cal <= RST_VCO_CAL;
      pd_word <= RST_PD;
      exact <= RST_EXACT;
    end else begin
      vco_cal <= next_vco_cal;
      pd_word <= next_pd_word;
      exact <= next_exact;
    end
  end

  // Read data in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 24'h000000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFS_VCO_CAL: next_rdata = vco_cal;
        OFS_PD: next_rdata = pd_word;
        OFS_EXACT: next_rdata = exact;
        default: next_rdata = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 24'h000000;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  // Calibration and link clock enable from the reference
  pcr_cal_divider u_div (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .sel(clk_sel),
    .tick(cal_tick)
  );

  // Tuning voltage measurement window
  pcr_window_timer u_win (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .start(win_start),
    .step(RDIV_TICK),
    .code(win_code),
    .busy(win_busy),
    .done(win_done)
  );

  // Trigger qualification; an idle start clears pending, a trigger while busy sets it
  always_comb begin
    trig_ok = OSC_REG_WRITE && !xfer_block;
    go = (pending && !xfer_block) || trig_ok;
    next_pending = pending;
    next_word_hold = word_hold;
    if (trig_ok) begin
      next_word_hold = OSC_WORD;
    end
    if (state == CAL_IDLE && go) begin
      next_pending = 1'b0;
    end
    if (trig_ok && !(state == CAL_IDLE)) begin
      next_pending = 1'b1;
    end
  end

  // Calibration state machine and oscillator serial link
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_phase = phase;
    next_link_en = OSC_LINK_EN;
    next_link_clk = OSC_LINK_CLK;
    next_link_data = OSC_LINK_DATA;
    win_start = 1'b0;
    unique case (state)
      CAL_IDLE: begin
        if (go) begin
          next_shift = trig_ok ? OSC_WORD : word_hold;
          next_bit_cnt = 5'h00;
          next_phase = 1'b0;
          if (!autocal_off) begin
            next_state = CAL_MEASURE;
            win_start = 1'b1;
          end else begin
            next_state = CAL_XFER;
          end
        end
      end
      CAL_MEASURE: begin
        if (win_done) begin
          next_state = CAL_XFER;
        end
      end
      CAL_XFER: begin
        if (cal_tick) begin
          next_link_en = 1'b1;
          if (!phase) begin
            next_link_clk = 1'b0;
            next_link_data = shift[LINK_BITS-1];
            next_phase = 1'b1;
          end else begin
            next_link_clk = 1'b1;
            next_shift = {shift[LINK_BITS-2:0], 1'b0};
            next_bit_cnt = bit_cnt + 5'h01;
            next_phase = 1'b0;
            if (bit_cnt == 5'(LINK_BITS - 1)) begin
              next_state = CAL_STOP;
            end
          end
        end
      end
      CAL_STOP: begin
        if (cal_tick) begin
          next_link_en = 1'b0;
          next_link_clk = 1'b0;
          next_link_data = 1'b0;
          next_state = CAL_IDLE;
        end
      end
    endcase
    next_cal_busy = (next_state != CAL_IDLE);
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= CAL_IDLE;
      pending <= 1'b0;
      word_hold <= 16'h0000;
      shift <= 16'h0000;
      bit_cnt <= 5'h00;
      phase <= 1'b0;
      OSC_LINK_EN <= 1'b0;
      OSC_LINK_CLK <= 1'b0;
      OSC_LINK_DATA <= 1'b0;
      CAL_BUSY <= 1'b0;
    end else begin
      state <= next_state;
      pending <= next_pending;
      word_hold <= next_word_hold;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      phase <= next_phase;
      OSC_LINK_EN <= next_link_en;
      OSC_LINK_CLK <= next_link_clk;
      OSC_LINK_DATA <= next_link_data;
      CAL_BUSY <= next_cal_busy;
    end
  end

  // Charge pump gating, forcing and slip boost
  always_comb begin
    err = DET_UP_RAW ^ DET_DN_RAW;
    next_err_cnt = 5'h00;
    if (err) begin
      next_err_cnt = (err_cnt == CSP_SAT) ? CSP_SAT : err_cnt + 5'h01;
    end
    next_cp_up = pd_cfg.force_up || (pd_cfg.up_en && DET_UP_RAW);
    next_cp_dn = pd_cfg.force_dn || (pd_cfg.dn_en && DET_DN_RAW);
    next_boost = (pd_cfg.csp != 2'h0) && err &&
      (next_err_cnt >= pcr_csp_limit(pd_cfg.csp));
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      err_cnt <= 5'h00;
      CP_UP <= 1'b0;
      CP_DN <= 1'b0;
      CSP_BOOST <= 1'b0;
    end else begin
      err_cnt <= next_err_cnt;
      CP_UP <= next_cp_up;
      CP_DN <= next_cp_dn;
      CSP_BOOST <= next_boost;
    end
  end

  // Static configuration outputs and window status, registered
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CAL_ENABLED <= 1'b0;
      WINDOW_ACTIVE <= 1'b0;
      DET_RESET_DELAY <= 3'h0;
      SDO_DRIVE_3V3 <= 1'b0;
      EXACT_MODE_EN <= 1'b0;
      EXACT_CHANNELS <= 14'h0000;
    end else begin
      CAL_ENABLED <= !autocal_off;
      WINDOW_ACTIVE <= win_busy;
      DET_RESET_DELAY <= pd_cfg.delay_sel;
      SDO_DRIVE_3V3 <= pd_cfg.lvl_3v3;
      EXACT_MODE_EN <= (chan_cnt >= EX_MIN_CNT);
      EXACT_CHANNELS <= chan_cnt;
    end
  end

endmodule

// File: test/pcr_properties.sv
module pcr_properties
  import pcr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [23:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic RDIV_TICK,
  input wire logic DET_UP_RAW,
  input wire logic DET_DN_RAW,
  input wire logic CAL_ENABLED,
  input wire logic CAL_BUSY,
  input wire logic WINDOW_ACTIVE,
  input wire logic OSC_LINK_EN,
  input wire logic OSC_LINK_CLK,
  input wire logic CP_UP,
  input wire logic CP_DN,
  input wire logic CSP_BOOST,
  input wire logic SDO_DRIVE_3V3,
  input wire logic EXACT_MODE_EN,
  input wire logic [13:0] EXACT_CHANNELS
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] vc;
  logic tk;
  logic [8:0] wt;
  logic [23:0] pd;
  logic [23:0] ex;
  logic [5:0] hi;
  logic [5:0] ratio;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Shadow registers and link clock high-time counter
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      vc <= RST_VCO_CAL;
      pd <= RST_PD;
      ex <= RST_EXACT;
      hi <= 6'h00;
      tk <= 1'b0;
      wt <= 9'h000;
    end else begin
      tk <= RDIV_TICK;
      wt <= WINDOW_ACTIVE ? wt + 9'(tk) : 9'h000;
      if (REG_WR && REG_ADDR == OFS_VCO_CAL) vc <= REG_WDATA;
      if (REG_WR && REG_ADDR == OFS_PD) pd <= REG_WDATA;
      if (REG_WR && REG_ADDR == OFS_EXACT) ex <= REG_WDATA;
      hi <= OSC_LINK_CLK ? hi + 6'h01 : 6'h00;
    end
  end

  // Cycles per link clock phase for the selected divider
  assign ratio = (vc[14:13] == 2'h0) ? 6'h01 : (vc[14:13] == 2'h1) ? 6'h04 :
                 (vc[14:13] == 2'h2) ? 6'h10 : 6'h20;

  chk_cal_enable: assert property ($past(RST_N) |-> CAL_ENABLED == !$past(vc[11]))
    else $error("calibration enable wrong");
  chk_no_transfer: assert property (vc[12] && !CAL_BUSY |=> !CAL_BUSY)
    else $error("transfer started while suppressed");
  chk_link_clock: assert property ($fell(OSC_LINK_CLK) |-> hi == ratio)
    else $error("link clock phase length wrong");
  chk_up_path: assert property (CP_UP == $past(pd[9] | (pd[5] & DET_UP_RAW)))
    else $error("up output wrong");
  chk_down_path: assert property (CP_DN == $past(pd[10] | (pd[6] & DET_DN_RAW)))
    else $error("down output wrong");
  chk_slip_off: assert property ((pd[8:7] == 2'h0) [*3] |-> !CSP_BOOST)
    else $error("boost while slip prevention off");
  chk_drive_level: assert property (SDO_DRIVE_3V3 == $past(pd[22]))
    else $error("drive level wrong");
  chk_exact_mode: assert property (EXACT_MODE_EN == ($past(ex[13:0]) >= 14'h0002) &&
    EXACT_CHANNELS == $past(ex[13:0]))
    else $error("exact mode wrong");
  chk_window_len: assert property ($fell(WINDOW_ACTIVE) |-> wt == (9'h001 << vc[2:0]))
    else $error("window length wrong");
  chk_window_start: assert property ($rose(WINDOW_ACTIVE) |-> CAL_BUSY && !vc[11])
    else $error("window without calibration");

  cover property ($rose(WINDOW_ACTIVE));
  cover property ($fell(OSC_LINK_EN));
  cover property (CSP_BOOST);
endmodule

bind pcr_top pcr_properties u_chk (.*);

// File: test/pcr_osc_rx.sv
module pcr_osc_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic sclk,
  input wire logic sdata,
  output logic [15:0] word,
  output logic [7:0] count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh;
  logic ps;
  logic pe;

  // Shifts on link clock rise, keeps the word when the frame closes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= 16'h0000;
      ps <= 1'b0;
      pe <= 1'b0;
      word <= 16'h0000;
      count <= 8'h00;
    end else begin
      ps <= sclk;
      pe <= en;
      if (en && sclk && !ps) sh <= {sh[14:0], sdata};
      if (pe && !en) begin
        word <= sh;
        count <= count + 8'h01;
      end
    end
  end
endmodule

// File: test/tb_pcr_top.sv
module tb_pcr_top
  import pcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, owr = 0, tick = 0, up = 0, dn = 0;
  logic [7:0] addr = 8'h00;
  logic [23:0] wd = 24'h0, rdata, pdv;
  logic [15:0] ow = 16'h0, rxw;
  logic cal_en, busy, win, len, lclk, ldat, boost, lvl, exen, cpu, cpd, saw_win = 0;
  logic [2:0] dly;
  logic [13:0] exch;
  logic [13:0] xv [4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3fff};
  logic [7:0] nrx;
  int n_mismatch = 0, checks = 0, cyc = 0;

  pcr_top dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .OSC_REG_WRITE(owr), .OSC_WORD(ow), .RDIV_TICK(tick),
    .DET_UP_RAW(up), .DET_DN_RAW(dn), .CAL_ENABLED(cal_en), .CAL_BUSY(busy),
    .WINDOW_ACTIVE(win), .OSC_LINK_EN(len), .OSC_LINK_CLK(lclk), .OSC_LINK_DATA(ldat),
    .DET_RESET_DELAY(dly), .CP_UP(cpu), .CP_DN(cpd), .CSP_BOOST(boost),
    .SDO_DRIVE_3V3(lvl), .EXACT_MODE_EN(exen), .EXACT_CHANNELS(exch));
  pcr_osc_rx rx (.clk(clk), .rst_n(rst_n), .en(len), .sclk(lclk), .sdata(ldat),
    .word(rxw), .count(nrx));

  always #5 clk = ~clk;

  // Divider ticks, window watch and run limit
  always @(posedge clk) begin
    cyc++;
    tick <= (cyc % 4 == 0);
    if (win === 1'b1) saw_win <= 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task conclude;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [23:0] s, input logic [23:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task settle;
    @(posedge clk);
    #1;
  endtask

  task wrr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [23:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task trig(input logic [15:0] w);
    @(posedge clk);
    owr <= 1'b1;
    ow <= w;
    @(posedge clk);
    owr <= 1'b0;
  endtask

  // Waits for the calibration engine to go idle, bounded
  task idle;
    int k;
    k = 0;
    #1;
    while (busy === 1'b1 && k < 4000) begin
      settle();
      k++;
    end
    if (k >= 4000) n_mismatch++;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    settle();
    chk(24'(cal_en), 24'h1);
    chk(24'(dly), 24'h1);
    chk(24'(exen), 24'h0);
    rdc(OFS_VCO_CAL, RST_VCO_CAL);
    rdc(OFS_PD, RST_PD);
    wrr(8'h0d, 24'h123456);
    rdc(8'h0d, 24'h0);
    for (int i = 0; i < 32; i++) begin
      pdv = {1'b0, i[0] ^ i[1], 11'h1f0, i[4], i[3], 2'b00, i[2], i[1], 2'b00, 3'b001};
      wrr(OFS_PD, pdv);
      up <= i[0];
      dn <= i[0];
      settle();
      chk(24'(cpu), 24'(i[3] | (i[1] & i[0])));
      chk(24'(cpd), 24'(i[4] | (i[2] & i[0])));
      chk(24'(lvl), 24'(i[0] ^ i[1]));
      rdc(OFS_PD, pdv);
    end
    for (int m = 0; m < 4; m++) begin
      wrr(OFS_PD, RST_PD | (24'(m) << 7));
      up <= 1'b1;
      dn <= 1'b0;
      repeat (6) settle();
      chk(24'(boost), 24'(m != 0));
      @(posedge clk);
      up <= 1'b0;
      repeat (6) settle();
      chk(24'(boost), 24'h0);
    end
    for (int j = 0; j < 4; j++) begin
      wrr(OFS_EXACT, 24'(xv[j]));
      rdc(OFS_EXACT, 24'(xv[j]));
      chk(24'(exen), 24'(xv[j] >= 14'h0002));
      chk(24'(exch), 24'(xv[j]));
    end
    for (int s = 0; s < 4; s++) begin
      wrr(OFS_VCO_CAL, {9'h0, s[1:0], 1'b0, 1'b1, 11'h205});
      settle();
      chk(24'(cal_en), 24'h0);
      trig(16'hc3a5 + 16'(s));
      idle();
      settle();
      chk(24'(rxw), 24'(16'hc3a5 + 16'(s)));
      chk(24'(nrx), 24'(s + 1));
    end
    wrr(OFS_VCO_CAL, 24'h003a05);
    trig(16'h1234);
    repeat (3) settle();
    chk(24'(busy), 24'h0);
    chk(24'(nrx), 24'h4);
    wrr(OFS_VCO_CAL, 24'h000201);
    trig(16'h0f0f);
    trig(16'hf0f0);
    idle();
    settle();
    chk(24'(rxw), 24'h000f0f);
    chk(24'(nrx), 24'h5);
    repeat (4) settle();
    idle();
    settle();
    chk(24'(saw_win), 24'h1);
    chk(24'(nrx), 24'h6);
    chk(24'(rxw), 24'h00f0f0);
    conclude();
  end
endmodule
